// *** hw/pmtr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE_01: program store holds 4096 sixteen-bit words, fetched by the program counter.
// RULE_02: after reset the program counter is zero and fetching starts there.
// RULE_03: table read address comes from low and high pointer bytes set beforehand.
// RULE_04: table read puts low byte to named data register, high byte to hold.
// RULE_05: normal table reads reach sector 0; extended reads reach every sector.
// RULE_06: last-page reads use word 0F00H plus low pointer, ignoring high pointer.
// RULE_07: every table read takes two instruction cycles.
// RULE_08: the table high-byte hold register is readable and writable.
// RULE_09: last-page reads need no high pointer; its value never changes the address.
// RULE_10: programming moves words over one shared data line, clock from programmer.
// RULE_11: debug port has one two-way data line and one input clock.
// RULE_12: while debugging, other functions on the two pins have no effect.
// RULE_13: the shared pins still serve programming data and clock when programming.
// RULE_14: normal table address is high pointer bits 3..0 above low pointer.
// RULE_15: table read's second cycle uses the read port; prefetch is suppressed.
module pmtr_top #(
	parameter int unsigned SECTOR_WORDS = pmtr_pkg::STORE_WORDS
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic jump_in,
	input wire logic [11:0] jump_addr_in,
	input wire pmtr_pkg::pmtr_tbl_cmd_t tbl_cmd_in,
	input wire logic tblp_wr_in,
	input wire logic tbhp_wr_in,
	input wire logic hold_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire pmtr_pkg::pmtr_store_wr_t store_wr_in,
	input wire logic prog_mode_in,
	input wire logic debug_mode_in,
	input wire pmtr_pkg::pmtr_pin_drv_t gpio_drv_in,
	input wire pmtr_pkg::pmtr_pin_drv_t serial_drv_in,
	input wire logic pin_data_in,
	input wire logic pin_clk_in,
	output logic [15:0] instr_out,
	output logic [11:0] instr_addr_out,
	output logic instr_valid_out,
	output logic [11:0] pc_out,
	output logic busy_out,
	output pmtr_pkg::pmtr_dm_wr_t dm_wr_out,
	output logic [7:0] table_upper_byte_hold_out,
	output logic [7:0] tblp_out,
	output logic [7:0] tbhp_out,
	output pmtr_pkg::pmtr_pin_drv_t pin_drv_out,
	output logic prog_serial_data_out,
	output logic prog_serial_clock_out,
	output logic debug_serial_data_out,
	output logic debug_serial_clock_out,
	output logic gpio_data_rd_out,
	output logic gpio_clk_rd_out,
	output logic serial_role_out
);
	localparam logic [11:0] SECTOR_MASK = 12'(SECTOR_WORDS - 1);

	// ==========================================================
	// address forming
	function automatic logic [11:0] tbl_addr(
		input pmtr_pkg::pmtr_tbl_kind_t kind,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		logic [11:0] full;
		logic [11:0] last;
		full = {hi[pmtr_pkg::HIGH_PTR_USED-1:0], lo}; // RULE_14 RULE_03
		last = {pmtr_pkg::LAST_PAGE_HIGH, lo}; // RULE_06 RULE_09
		case (kind)
			pmtr_pkg::PMTR_TBL_NORM: tbl_addr = full & SECTOR_MASK; // RULE_05
			pmtr_pkg::PMTR_TBL_NORM_LAST: tbl_addr = last;
			pmtr_pkg::PMTR_TBL_EXT: tbl_addr = full; // RULE_05
			pmtr_pkg::PMTR_TBL_EXT_LAST: tbl_addr = last;
			default: tbl_addr = full;
		endcase
	endfunction

	// ==========================================================
	// state
	pmtr_pkg::pmtr_state_t state_r, state_nxt;
	logic [11:0] pc_r, pc_nxt;
	logic [15:0] instr_r, instr_nxt;
	logic [11:0] instr_addr_r, instr_addr_nxt;
	logic instr_valid_r, instr_valid_nxt;
	logic [11:0] tbl_addr_r, tbl_addr_nxt;
	logic [7:0] dest_r, dest_nxt;
	logic [7:0] tblp_r, tblp_nxt;
	logic [7:0] tbhp_r, tbhp_nxt;
	logic [7:0] hold_r, hold_nxt;
	pmtr_pkg::pmtr_dm_wr_t dm_wr_r, dm_wr_nxt;
	logic [11:0] rd_addr;
	logic [15:0] rd_word;

	// ==========================================================
	// program store
	// RULE_15
	assign rd_addr = (state_r == pmtr_pkg::PMTR_ST_TABLE) ? tbl_addr_r : pc_r;

	pmtr_store #(
		.ADDR_W(pmtr_pkg::ADDR_W),
		.WORD_W(pmtr_pkg::WORD_W),
		.DEPTH(pmtr_pkg::STORE_WORDS)
	) u_store ( // RULE_01
		.sys_clk_in(sys_clk_in),
		.wr_en_in(store_wr_in.valid),
		.wr_addr_in(store_wr_in.addr),
		.wr_data_in(store_wr_in.data),
		.rd_addr_in(rd_addr),
		.rd_data_out(rd_word)
	);

	// ==========================================================
	// fetch and table read sequencing
	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		instr_nxt = instr_r;
		instr_addr_nxt = instr_addr_r;
		instr_valid_nxt = 1'b0;
		tbl_addr_nxt = tbl_addr_r;
		dest_nxt = dest_r;
		dm_wr_nxt = '0;
		tblp_nxt = tblp_wr_in ? sfr_wdata_in : tblp_r;
		tbhp_nxt = tbhp_wr_in ? sfr_wdata_in : tbhp_r;
		hold_nxt = hold_wr_in ? sfr_wdata_in : hold_r; // RULE_08
		case (state_r)
			pmtr_pkg::PMTR_ST_FETCH: begin
				if (jump_in) begin
					// word at the old pc is dropped: the dummy cycle of a branch
					pc_nxt = jump_addr_in;
				end else begin
					instr_nxt = rd_word;
					instr_addr_nxt = pc_r;
					instr_valid_nxt = 1'b1;
					pc_nxt = 12'(pc_r + 12'h001);
				end
				if (tbl_cmd_in.valid) begin
					// pointers as they stood before any write in this same cycle
					tbl_addr_nxt = tbl_addr(tbl_cmd_in.kind, tblp_r, tbhp_r); // RULE_03
					dest_nxt = tbl_cmd_in.dest;
					state_nxt = pmtr_pkg::PMTR_ST_TABLE; // RULE_07
				end
			end
			pmtr_pkg::PMTR_ST_TABLE: begin
				// read port busy with the table word: no prefetch, pc holds
				dm_wr_nxt.valid = 1'b1; // RULE_15
				dm_wr_nxt.addr = dest_r;
				dm_wr_nxt.data = rd_word[7:0]; // RULE_04
				hold_nxt = rd_word[15:8]; // RULE_04
				state_nxt = pmtr_pkg::PMTR_ST_FETCH; // RULE_07
			end
			default: begin
				state_nxt = pmtr_pkg::PMTR_ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_r <= pmtr_pkg::PMTR_ST_FETCH;
			pc_r <= pmtr_pkg::RESET_VECTOR; // RULE_02
			instr_r <= pmtr_pkg::WORD_RST;
			instr_addr_r <= pmtr_pkg::RESET_VECTOR;
			instr_valid_r <= 1'b0;
			tbl_addr_r <= pmtr_pkg::RESET_VECTOR;
			dest_r <= pmtr_pkg::PTR_RST;
			tblp_r <= pmtr_pkg::PTR_RST;
			tbhp_r <= pmtr_pkg::PTR_RST;
			hold_r <= pmtr_pkg::HOLD_RST;
			dm_wr_r <= '0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			instr_r <= instr_nxt;
			instr_addr_r <= instr_addr_nxt;
			instr_valid_r <= instr_valid_nxt;
			tbl_addr_r <= tbl_addr_nxt;
			dest_r <= dest_nxt;
			tblp_r <= tblp_nxt;
			tbhp_r <= tbhp_nxt;
			hold_r <= hold_nxt;
			dm_wr_r <= dm_wr_nxt;
		end
	end

	// ==========================================================
	// shared serial pins
	logic data_meta_r, data_meta_nxt;
	logic data_sync_r, data_sync_nxt;
	logic clk_meta_r, clk_meta_nxt;
	logic clk_sync_r, clk_sync_nxt;
	logic prog_r, prog_nxt;
	logic dbg_r, dbg_nxt;
	logic role_r, role_nxt;
	logic gpio_data_rd_r, gpio_data_rd_nxt;
	logic gpio_clk_rd_r, gpio_clk_rd_nxt;
	pmtr_pkg::pmtr_pin_drv_t pin_drv_r, pin_drv_nxt;

	always_comb begin
		data_meta_nxt = pin_data_in;
		data_sync_nxt = data_meta_r;
		clk_meta_nxt = pin_clk_in;
		clk_sync_nxt = clk_meta_r;
		// programming outranks debugging on the same two pins
		prog_nxt = prog_mode_in; // RULE_13
		dbg_nxt = debug_mode_in & ~prog_mode_in;
		role_nxt = prog_mode_in | debug_mode_in;
		if (prog_mode_in || debug_mode_in) begin
			// clock always comes from outside; data pin driven by serial engine
			pin_drv_nxt.data_o = serial_drv_in.data_o; // RULE_10 RULE_11
			pin_drv_nxt.data_oe = serial_drv_in.data_oe;
			pin_drv_nxt.clk_o = 1'b0;
			pin_drv_nxt.clk_oe = 1'b0; // RULE_10 RULE_11
			gpio_data_rd_nxt = 1'b0; // RULE_12
			gpio_clk_rd_nxt = 1'b0; // RULE_12
		end else begin
			pin_drv_nxt = gpio_drv_in;
			gpio_data_rd_nxt = data_sync_r;
			gpio_clk_rd_nxt = clk_sync_r;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			data_meta_r <= 1'b0;
			data_sync_r <= 1'b0;
			clk_meta_r <= 1'b0;
			clk_sync_r <= 1'b0;
			prog_r <= 1'b0;
			dbg_r <= 1'b0;
			role_r <= 1'b0;
			gpio_data_rd_r <= 1'b0;
			gpio_clk_rd_r <= 1'b0;
			pin_drv_r <= '0;
		end else begin
			data_meta_r <= data_meta_nxt;
			data_sync_r <= data_sync_nxt;
			clk_meta_r <= clk_meta_nxt;
			clk_sync_r <= clk_sync_nxt;
			prog_r <= prog_nxt;
			dbg_r <= dbg_nxt;
			role_r <= role_nxt;
			gpio_data_rd_r <= gpio_data_rd_nxt;
			gpio_clk_rd_r <= gpio_clk_rd_nxt;
			pin_drv_r <= pin_drv_nxt;
		end
	end

	// serial receive taps: sync stage and role flop are both registers
	logic prog_data_r, prog_clk_r, dbg_data_r, dbg_clk_r;
	logic prog_data_nxt, prog_clk_nxt, dbg_data_nxt, dbg_clk_nxt;

	always_comb begin
		prog_data_nxt = prog_r & data_sync_r; // RULE_13
		prog_clk_nxt = prog_r & clk_sync_r;
		dbg_data_nxt = dbg_r & data_sync_r;
		dbg_clk_nxt = dbg_r & clk_sync_r;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			prog_data_r <= 1'b0;
			prog_clk_r <= 1'b0;
			dbg_data_r <= 1'b0;
			dbg_clk_r <= 1'b0;
		end else begin
			prog_data_r <= prog_data_nxt;
			prog_clk_r <= prog_clk_nxt;
			dbg_data_r <= dbg_data_nxt;
			dbg_clk_r <= dbg_clk_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign instr_out = instr_r;
	assign instr_addr_out = instr_addr_r;
	assign instr_valid_out = instr_valid_r;
	assign pc_out = pc_r;
	assign busy_out = state_r;
	assign dm_wr_out = dm_wr_r;
	assign table_upper_byte_hold_out = hold_r;
	assign tblp_out = tblp_r;
	assign tbhp_out = tbhp_r;
	assign pin_drv_out = pin_drv_r;
	assign prog_serial_data_out = prog_data_r;
	assign prog_serial_clock_out = prog_clk_r;
	assign debug_serial_data_out = dbg_data_r;
	assign debug_serial_clock_out = dbg_clk_r;
	assign gpio_data_rd_out = gpio_data_rd_r;
	assign gpio_clk_rd_out = gpio_clk_rd_r;
	assign serial_role_out = role_r;
endmodule
`default_nettype wire

// *** pkg/pmtr_pkg.sv ***
`default_nettype none
package pmtr_pkg;

	// ==========================================================
	// widths and sizes
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned STORE_WORDS = 4096;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned TBL_CYCLES = 2;

	// ==========================================================
	// addresses and reset values
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [11:0] LAST_PAGE_BASE = 12'hF00;
	localparam logic [3:0] LAST_PAGE_HIGH = 4'hF;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] HOLD_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam int unsigned HIGH_PTR_USED = 4;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		PMTR_TBL_NORM = 2'b00,
		PMTR_TBL_NORM_LAST = 2'b01,
		PMTR_TBL_EXT = 2'b10,
		PMTR_TBL_EXT_LAST = 2'b11
	} pmtr_tbl_kind_t;

	typedef enum logic {
		PMTR_ST_FETCH = 1'b0,
		PMTR_ST_TABLE = 1'b1
	} pmtr_state_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		pmtr_tbl_kind_t kind;
		logic [7:0] dest;
	} pmtr_tbl_cmd_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} pmtr_dm_wr_t;

	typedef struct packed {
		logic valid;
		logic [11:0] addr;
		logic [15:0] data;
	} pmtr_store_wr_t;

	typedef struct packed {
		logic data_o;
		logic data_oe;
		logic clk_o;
		logic clk_oe;
	} pmtr_pin_drv_t;

endpackage
`default_nettype wire

// *** hw/pmtr_store.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// program store: one loading port, one combinational read port
module pmtr_store #(
	parameter int unsigned ADDR_W = pmtr_pkg::ADDR_W,
	parameter int unsigned WORD_W = pmtr_pkg::WORD_W,
	parameter int unsigned DEPTH = pmtr_pkg::STORE_WORDS
) (
	input wire logic sys_clk_in,
	input wire logic wr_en_in,
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic [WORD_W-1:0] wr_data_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [WORD_W-1:0] rd_data_out
);
	// nonvolatile contents: no reset on purpose
	logic [WORD_W-1:0] mem_r [DEPTH];

	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
	end

	assign rd_data_out = mem_r[rd_addr_in];
endmodule
`default_nettype wire

// *** tb/pmtr_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmtr_chk #(
	parameter int unsigned SECTOR_WORDS = 4096
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire pmtr_pkg::pmtr_tbl_cmd_t tbl_cmd_in,
	input wire logic prog_mode_in,
	input wire logic [11:0] pc_out,
	input wire logic [11:0] instr_addr_out,
	input wire logic instr_valid_out,
	input wire logic busy_out,
	input wire pmtr_pkg::pmtr_dm_wr_t dm_wr_out,
	input wire pmtr_pkg::pmtr_pin_drv_t pin_drv_out,
	input wire logic prog_serial_data_out,
	input wire logic debug_serial_data_out,
	input wire logic serial_role_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// ====
	// table reads
	chk_tbl_two: assert property (tbl_cmd_in.valid && !busy_out |=> busy_out ##1 !busy_out)
		else $error("table read length");
	chk_tbl_refuse: assert property (tbl_cmd_in.valid && busy_out |=> !busy_out)
		else $error("request taken while busy");
	chk_tbl_dest: assert property (tbl_cmd_in.valid && !busy_out |-> ##2 dm_wr_out.valid
		&& dm_wr_out.addr == $past(tbl_cmd_in.dest, 2))
		else $error("low byte destination");
	chk_dm_cause: assert property (dm_wr_out.valid |-> $past(busy_out) && !busy_out)
		else $error("stray data write");
	chk_no_prefetch: assert property (busy_out |=> !instr_valid_out && $stable(pc_out))
		else $error("fetch in table cycle");
	// ====
	// fetch
	chk_fetch_addr: assert property (instr_valid_out |-> instr_addr_out == $past(pc_out))
		else $error("fetch address");
	chk_boot_vector: assert property ($fell(reset_in) |-> pc_out == 12'h000
		##1 instr_valid_out && instr_addr_out == 12'h000)
		else $error("reset vector");
	// ====
	// shared pins
	chk_prog_gate: assert property (!prog_mode_in [*3] |-> !prog_serial_data_out)
		else $error("programming tap open");
	chk_dbg_prio: assert property (prog_mode_in [*3] |-> !debug_serial_data_out)
		else $error("debug tap during programming");
	chk_role_clk: assert property (serial_role_out |-> !pin_drv_out.clk_oe)
		else $error("clock pin driven");
	cover property (tbl_cmd_in.valid && busy_out);
	cover property (dm_wr_out.valid);
	cover property (serial_role_out);
endmodule
bind pmtr_top pmtr_chk #(.SECTOR_WORDS(SECTOR_WORDS)) u_chk (
	.sys_clk_in, .reset_in, .tbl_cmd_in, .prog_mode_in, .pc_out, .instr_addr_out,
	.instr_valid_out, .busy_out, .dm_wr_out, .pin_drv_out, .prog_serial_data_out,
	.debug_serial_data_out, .serial_role_out
);
`default_nettype wire

// *** tb/pmtr_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmtr_cpu_model (
	input wire logic sys_clk_in,
	output pmtr_pkg::pmtr_tbl_cmd_t tbl_cmd_out,
	output logic tblp_wr_out,
	output logic tbhp_wr_out,
	output logic hold_wr_out,
	output logic [7:0] sfr_wdata_out
);
	int left_r = 0;
	initial tbl_cmd_out = '0;
	initial {tblp_wr_out, tbhp_wr_out, hold_wr_out, sfr_wdata_out} = '0;
	// ====
	// register writes: pointers are loaded before a read
	task automatic sfr(input int sel, input logic [7:0] v);
		@(posedge sys_clk_in);
		sfr_wdata_out <= v;
		{tblp_wr_out, tbhp_wr_out, hold_wr_out} <= 3'h4 >> sel;
		@(posedge sys_clk_in);
		{tblp_wr_out, tbhp_wr_out, hold_wr_out} <= 3'h0;
		sfr_wdata_out <= ~v;
	endtask
	// ====
	// table read; dbl leaves the request up into the busy cycle
	task automatic tabrd(input logic [1:0] k, input logic [7:0] d, input logic dbl);
		@(posedge sys_clk_in);
		tbl_cmd_out <= {1'b1, k, d};
		left_r <= dbl ? 2 : 1;
	endtask
	always @(posedge sys_clk_in) begin
		if (left_r > 0) begin
			left_r <= left_r - 1;
			if (left_r == 1) tbl_cmd_out.valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int SW = 256;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic prog_mode_in = 1'b0;
	logic debug_mode_in = 1'b0;
	logic pin_data_in = 1'b0;
	logic pin_clk_in = 1'b0;
	logic jump_in = 1'b0;
	logic [11:0] jump_addr_in = 12'h000;
	pmtr_pkg::pmtr_store_wr_t store_wr_in = '0;
	pmtr_pkg::pmtr_tbl_cmd_t tbl_cmd;
	pmtr_pkg::pmtr_dm_wr_t dm_wr;
	pmtr_pkg::pmtr_pin_drv_t pin_drv;
	logic tblp_wr, tbhp_wr, hold_wr, instr_valid, busy, prog_d, dbg_d, gpio_d, role;
	logic prog_c, dbg_c, gpio_c;
	logic [7:0] wdata, hold, tblp, tbhp;
	logic [11:0] instr_addr, pc;
	logic [15:0] instr;
	int num_errors = 0;
	int n_compared = 0;
	initial forever #5 sys_clk_in = ~sys_clk_in;
	pmtr_cpu_model u_cpu (.sys_clk_in(sys_clk_in), .tbl_cmd_out(tbl_cmd),
		.tblp_wr_out(tblp_wr), .tbhp_wr_out(tbhp_wr), .hold_wr_out(hold_wr),
		.sfr_wdata_out(wdata));
	// gpio and serial drive codes differ in data_o, data_oe and clk_o (clk_oe is 1 in both), so a wrong source shows
	pmtr_top #(.SECTOR_WORDS(SW)) u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.jump_in(jump_in), .jump_addr_in(jump_addr_in), .tbl_cmd_in(tbl_cmd),
		.tblp_wr_in(tblp_wr),
		.tbhp_wr_in(tbhp_wr), .hold_wr_in(hold_wr), .sfr_wdata_in(wdata),
		.store_wr_in(store_wr_in), .prog_mode_in(prog_mode_in),
		.debug_mode_in(debug_mode_in), .gpio_drv_in(4'h5), .serial_drv_in(4'hB),
		.pin_data_in(pin_data_in), .pin_clk_in(pin_clk_in), .instr_out(instr),
		.instr_addr_out(instr_addr), .instr_valid_out(instr_valid), .pc_out(pc),
		.busy_out(busy), .dm_wr_out(dm_wr), .table_upper_byte_hold_out(hold),
		.tblp_out(tblp), .tbhp_out(tbhp), .pin_drv_out(pin_drv),
		.prog_serial_data_out(prog_d), .prog_serial_clock_out(prog_c),
		.debug_serial_data_out(dbg_d), .debug_serial_clock_out(dbg_c),
		.gpio_data_rd_out(gpio_d), .gpio_clk_rd_out(gpio_c),
		.serial_role_out(role));
	// ====
	// helpers
	function automatic logic [15:0] wd(input logic [11:0] a);
		return {a[3:0] ^ 4'h5, a};
	endfunction
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic do_reset;
		reset_in <= 1'b1;
		repeat (12) @(posedge sys_clk_in);
		reset_in <= 1'b0;
	endtask
	task automatic test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ====
	// scenarios
	task automatic t_load;
		for (int a = 0; a < 4096; a++) begin
			@(posedge sys_clk_in);
			store_wr_in <= {1'b1, 12'(a), wd(12'(a))};
		end
		@(posedge sys_clk_in);
		store_wr_in <= '0;
	endtask
	task automatic t_boot;
		cyc(1);
		chk(instr_valid === 1'b1 && instr_addr === 12'h000, "boot fetch");
		chk(instr === wd(12'h000) && pc === 12'h001, "boot word");
		cyc(1);
		chk(instr_addr === 12'h001 && instr === wd(12'h001), "second fetch");
	endtask
	task automatic t_jump;
		@(posedge sys_clk_in);
		jump_in <= 1'b1;
		jump_addr_in <= 12'h123;
		@(posedge sys_clk_in);
		jump_in <= 1'b0;
		#1;
		chk(pc === 12'h123 && instr_valid === 1'b0, "jump bubble");
		cyc(1);
		chk(instr_addr === 12'h123 && instr === wd(12'h123), "jump fetch");
		chk(instr_valid === 1'b1 && pc === 12'h124, "jump resume");
	endtask
	task automatic t_tab(input logic [1:0] k, input logic [7:0] lo, hi, input logic dbl);
		logic [11:0] a;
		logic [15:0] w;
		a = k[0] ? {4'hF, lo} : {hi[3:0], lo};
		if (k == 2'b00) a = a & 12'(SW - 1);
		w = wd(a);
		u_cpu.sfr(0, lo);
		u_cpu.sfr(1, hi);
		#1;
		chk(tblp === lo && tbhp === hi, "pointer readback");
		u_cpu.tabrd(k, ~lo, dbl);
		cyc(1);
		chk(busy === 1'b1 && instr_valid === 1'b1, "first table cycle");
		cyc(1);
		chk(busy === 1'b0 && instr_valid === 1'b0, "second table cycle");
		chk(dm_wr === {1'b1, ~lo, w[7:0]}, "low byte");
		chk(hold === w[15:8], "high byte");
		cyc(1);
		chk(busy === 1'b0 && dm_wr.valid === 1'b0, "late request");
	endtask
	task automatic t_pin(input logic p, g);
		@(posedge sys_clk_in);
		prog_mode_in <= p;
		debug_mode_in <= g;
		pin_data_in <= 1'b1;
		pin_clk_in <= 1'b0;
		cyc(6);
		chk(prog_d === p && dbg_d === (g & ~p), "serial tap");
		chk(gpio_d === ~(p | g) && role === (p | g), "pin function");
		chk({prog_c, dbg_c, gpio_c} === 3'h0, "clock low");
		chk(pin_drv === ((p | g) ? 4'h8 : 4'h5), "pin drive");
		@(posedge sys_clk_in);
		pin_data_in <= 1'b0;
		pin_clk_in <= 1'b1;
		cyc(6);
		chk({prog_d, dbg_d, gpio_d} === 3'h0, "pad low");
		chk({prog_c, dbg_c, gpio_c} === {p, g & ~p, ~(p | g)}, "clock tap");
	endtask
	// ====
	// main sequence; the store survives the second reset
	initial begin
		do_reset();
		t_load();
		do_reset();
		t_boot();
		t_jump();
		t_tab(2'b00, 8'h45, 8'h03, 1'b0);
		t_tab(2'b10, 8'h45, 8'h03, 1'b1);
		t_tab(2'b10, 8'hFF, 8'hFE, 1'b0);
		t_tab(2'b01, 8'h06, 8'h0A, 1'b0);
		t_tab(2'b11, 8'hFF, 8'h55, 1'b0);
		u_cpu.sfr(2, 8'hC3);
		#1;
		chk(hold === 8'hC3, "hold write");
		t_pin(1'b1, 1'b0);
		t_pin(1'b0, 1'b1);
		t_pin(1'b1, 1'b1);
		t_pin(1'b0, 1'b0);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		num_errors++;
		$display("MISMATCH %0t timeout", $time);
		test_done();
	end
endmodule
`default_nettype wire
